//--- design/bmf_core.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Port C word writes pack two halves; big-endian fills upper half first.
// - Port C byte writes pack four bytes; big-endian fills top lane first.
// - Port B word reads unpack two halves; big-endian gives upper half first.
// - Port B byte reads unpack four bytes; big-endian goes top lane down.
// - Byte order is captured at reset; width selects stay static.
// - In byte reads the upper nine port B outputs are driven to zero.
// - Fall-through: port B ready and first data within three port B edges.
// - Port B ready drops when the final part of the last word is read.
// - Standard mode: port B empty flag rises on the second port B edge after a write.
// - Port B empty flag falls on the read removing the final part.
// - Fall-through: port A ready and data within three port A edges.
// - Only the port C edge completing a long word signals FIFO2 write.
// - Standard mode: port A empty flag rises on the second port A edge after a write.
// - Fall-through: port A input ready rises after a read frees FIFO1.
// - Standard mode: port A full flag rises after a read frees FIFO1.
// - Only the port B edge reading the final part frees FIFO1 space.
// - Port C input ready drops on the write completing the filling word.
// - Port C input ready rises after space opens in full FIFO2.
// - FIFO2 stores a whole long word on the last part write.
// - FIFO1 is read a long word at a time; the rest waits aside.
module bmf_core
    import bmf_pkg::*;
(
    input  wire logic              ref_clk,             // System clock
    input  wire logic              rst,                 // Async reset, high
    input  wire logic              psel,                // APB select
    input  wire logic              penable,             // APB enable
    input  wire logic              pwrite,              // APB direction
    input  wire logic [APB_AW-1:0] paddr,               // APB address
    input  wire logic [31:0]       pwdata,              // APB write data
    output logic      [31:0]       prdata,              // APB read data
    output logic                   pready,              // APB ready
    output logic                   pslverr,             // APB error
    input  wire logic              port_a_clock,        // Port A clock pin
    input  wire logic              port_b_clock,        // Port B clock pin
    input  wire logic              port_c_clock,        // Port C clock pin
    input  wire logic              a_write_en,          // Port A FIFO1 write
    input  wire logic              a_read_en,           // Port A FIFO2 read
    input  wire logic              b_read_en,           // Port B FIFO1 read
    input  wire logic              c_write_en,          // Port C FIFO2 write
    input  wire logic              byte_order_select,   // High: big-endian
    input  wire logic              port_b_width_select, // High: byte
    input  wire logic              port_c_width_select, // High: byte
    input  wire logic [WORD_W-1:0] a_data_in,           // Port A write data
    input  wire logic [HALF_W-1:0] c_data_in,           // Port C write data
    output logic      [WORD_W-1:0] a_data_out,          // Port A read data
    output logic      [HALF_W-1:0] b_data_out,          // Port B read data
    output logic                   port_a_input_ready,  // FIFO1 not full
    output logic                   port_a_output_ready, // FIFO2 data flag
    output logic                   port_b_output_ready, // FIFO1 data flag
    output logic                   port_c_input_ready   // FIFO2 not full
);

    function automatic logic [BASE_W-1:0] slot_base(
        input logic [1:0] idx,
        input logic       bm,
        input logic       big
    );
        logic [1:0] n;
        n = big ? ((bm ? LAST_BYTE : LAST_HALF) - idx) : idx;
        slot_base = bm ? BASE_W'(n * LANE_W) : BASE_W'(n * HALF_W);
    endfunction

    function automatic logic [1:0] last_idx(input logic bm);
        last_idx = bm ? LAST_BYTE : LAST_HALF;
    endfunction

    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic [2:0]        clk_prev_ff;
    logic [INIT_ST-1:0] init_sr_ff;
    logic              a_clk_s, b_clk_s, c_clk_s;
    logic              a_wr_s, a_rd_s, b_rd_s, c_wr_s;
    logic              be_s, bsz_s, csz_s;
    logic [WORD_W-1:0] a_din_s;
    logic [HALF_W-1:0] c_din_s;
    logic              a_edge, b_edge, c_edge, init_done;
    logic              be_ff, bbyte_ff, cbyte_ff, fall_through_mode_ff;

    // Pins pass two flops before use
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= {port_a_clock, port_b_clock, port_c_clock, a_write_en,
                         a_read_en, b_read_en, c_write_en, byte_order_select,
                         port_b_width_select, port_c_width_select, a_data_in,
                         c_data_in};
            sync2_ff <= sync1_ff;
        end
    end

    assign {a_clk_s, b_clk_s, c_clk_s, a_wr_s, a_rd_s, b_rd_s, c_wr_s, be_s,
            bsz_s, csz_s, a_din_s, c_din_s} = sync2_ff;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            clk_prev_ff <= '0;
        else
            clk_prev_ff <= {a_clk_s, b_clk_s, c_clk_s};
    end

    assign a_edge    = a_clk_s & ~clk_prev_ff[2];
    assign b_edge    = b_clk_s & ~clk_prev_ff[1];
    assign c_edge    = c_clk_s & ~clk_prev_ff[0];
    assign init_done = init_sr_ff[INIT_ST-1];

    // Config captured once synchronised pins are valid after reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            init_sr_ff <= '0;
            be_ff      <= 1'b0;
            bbyte_ff   <= 1'b0;
            cbyte_ff   <= 1'b0;
        end
        else
        begin
            init_sr_ff <= {init_sr_ff[INIT_ST-2:0], 1'b1};
            if (init_sr_ff[INIT_ST-2] && !init_done)
            begin
                be_ff    <= be_s;
                bbyte_ff <= bsz_s;
                cbyte_ff <= csz_s;
            end
        end
    end

    logic [WORD_W-1:0] mem1 [DEPTH];
    logic [WORD_W-1:0] mem2 [DEPTH];

    // Port A writes FIFO1
    logic [PTR_W-1:0]  a_wp_ff, a_rs1_ff, a_wp_nxt;
    logic              a_ira_ff, a_wr, a_full_nxt;
    // Port B reads FIFO1
    logic [PTR_W-1:0]  b_rp_ff, b_ws1_ff, b_ws2_ff, b_wsync, b_rp_nxt;
    logic [1:0]        b_idx_ff, b_idx_nxt;
    logic [WORD_W-1:0] b_lw_ff, b_src;
    logic [HALF_W-1:0] b_out_ff, b_part, b_src_hi;
    logic [BASE_W-1:0] b_base;
    logic              b_rdy_ff, b_rd, b_last, b_have, b_take, b_more, b_rdy_nxt;
    // Port A reads FIFO2
    logic [PTR_W-1:0]  a_rp_ff, a_ws1_ff, a_ws2_ff, a_wsync, a_rp_nxt;
    logic [WORD_W-1:0] a_out_ff;
    logic              a_ora_ff, a_rd, a_have, a_take, a_ora_nxt;
    // Port C writes FIFO2
    logic [PTR_W-1:0]  c_wp_ff, c_rs1_ff, c_wp_nxt;
    logic [1:0]        c_idx_ff;
    logic [WORD_W-1:0] c_pk_ff, c_word;
    logic [BASE_W-1:0] c_base;
    logic              c_irc_ff, c_wr, c_last, c_commit;

    always_comb
    begin
        a_wr       = a_wr_s && a_ira_ff;
        a_wp_nxt   = a_wr ? a_wp_ff + PTR_ONE : a_wp_ff;
        a_full_nxt = (a_wp_nxt - a_rs1_ff) == DEPTH_P;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            a_wp_ff  <= '0;
            a_rs1_ff <= '0;
            a_ira_ff <= 1'b0;
        end
        else if (a_edge && init_done)
        begin
            a_wp_ff  <= a_wp_nxt;
            a_rs1_ff <= b_rp_ff;
            a_ira_ff <= !a_full_nxt;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (a_edge && init_done && a_wr)
            mem1[a_wp_ff[ADDR_W-1:0]] <= a_din_s;
    end

    always_comb
    begin
        b_src     = (b_idx_ff == IDX0) ? mem1[b_rp_ff[ADDR_W-1:0]] : b_lw_ff;
        b_src_hi  = b_src[WORD_W-1 -: HALF_W];
        b_base    = slot_base(b_idx_ff, bbyte_ff, be_ff);
        b_part    = bbyte_ff ? {LANE_ZERO, b_src[b_base +: LANE_W]}
                             : b_src[b_base +: HALF_W];
        b_last    = b_idx_ff == last_idx(bbyte_ff);
        b_wsync   = fall_through_mode_ff ? b_ws2_ff : b_ws1_ff;
        b_have    = (b_idx_ff != IDX0) || (b_wsync != b_rp_ff);
        b_rd      = b_rd_s && b_rdy_ff;
        b_take    = fall_through_mode_ff ? (b_have && (!b_rdy_ff || b_rd)) : (b_rd && b_have);
        b_idx_nxt = b_take ? (b_last ? IDX0 : b_idx_ff + IDX1) : b_idx_ff;
        b_rp_nxt  = (b_take && b_last) ? b_rp_ff + PTR_ONE : b_rp_ff;
        b_more    = (b_idx_nxt != IDX0) || (b_wsync != b_rp_nxt);
        b_rdy_nxt = fall_through_mode_ff ? (b_take || (b_rdy_ff && !b_rd)) : b_more;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            b_ws1_ff <= '0;
            b_ws2_ff <= '0;
            b_rp_ff  <= '0;
            b_idx_ff <= IDX0;
            b_rdy_ff <= 1'b0;
            b_lw_ff  <= '0;
            b_out_ff <= '0;
        end
        else if (b_edge && init_done)
        begin
            b_ws1_ff <= a_wp_ff;
            b_ws2_ff <= b_ws1_ff;
            b_idx_ff <= b_idx_nxt;
            b_rp_ff  <= b_rp_nxt;
            b_rdy_ff <= b_rdy_nxt;
            if (b_take)
            begin
                b_out_ff <= b_part;
                if (b_idx_ff == IDX0)
                    b_lw_ff <= b_src;
            end
        end
    end

    always_comb
    begin
        a_wsync   = fall_through_mode_ff ? a_ws2_ff : a_ws1_ff;
        a_have    = a_wsync != a_rp_ff;
        a_rd      = a_rd_s && a_ora_ff;
        a_take    = fall_through_mode_ff ? (a_have && (!a_ora_ff || a_rd)) : (a_rd && a_have);
        a_rp_nxt  = a_take ? a_rp_ff + PTR_ONE : a_rp_ff;
        a_ora_nxt = fall_through_mode_ff ? (a_take || (a_ora_ff && !a_rd)) : (a_wsync != a_rp_nxt);
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            a_ws1_ff <= '0;
            a_ws2_ff <= '0;
            a_rp_ff  <= '0;
            a_ora_ff <= 1'b0;
            a_out_ff <= '0;
        end
        else if (a_edge && init_done)
        begin
            a_ws1_ff <= c_wp_ff;
            a_ws2_ff <= a_ws1_ff;
            a_rp_ff  <= a_rp_nxt;
            a_ora_ff <= a_ora_nxt;
            if (a_take)
                a_out_ff <= mem2[a_rp_ff[ADDR_W-1:0]];
        end
    end

    always_comb
    begin
        c_wr     = c_wr_s && c_irc_ff;
        c_last   = c_idx_ff == last_idx(cbyte_ff);
        c_base   = slot_base(c_idx_ff, cbyte_ff, be_ff);
        c_word   = c_pk_ff;
        if (cbyte_ff)
            c_word[c_base +: LANE_W] = c_din_s[LANE_W-1:0];
        else
            c_word[c_base +: HALF_W] = c_din_s;
        c_commit = c_wr && c_last;
        c_wp_nxt = c_commit ? c_wp_ff + PTR_ONE : c_wp_ff;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            c_idx_ff <= IDX0;
            c_pk_ff  <= '0;
            c_wp_ff  <= '0;
            c_rs1_ff <= '0;
            c_irc_ff <= 1'b0;
        end
        else if (c_edge && init_done)
        begin
            c_rs1_ff <= a_rp_ff;
            c_wp_ff  <= c_wp_nxt;
            c_irc_ff <= (c_wp_nxt - c_rs1_ff) != DEPTH_P;
            if (c_wr)
            begin
                c_pk_ff  <= c_word;
                c_idx_ff <= c_last ? IDX0 : c_idx_ff + IDX1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (c_edge && init_done && c_commit)
            mem2[c_wp_ff[ADDR_W-1:0]] <= c_word;
    end

    // APB slave, zero wait states
    logic        apb_setup, apb_hit;
    logic        pready_ff, pslverr_ff;
    logic [31:0] prdata_ff, rd_mux;
    logic [PTR_W-1:0] lvl1, lvl2;

    always_comb
    begin
        apb_setup = psel && !penable;
        lvl1      = a_wp_ff - b_rp_ff;
        lvl2      = c_wp_ff - a_rp_ff;
        apb_hit   = 1'b1;
        rd_mux    = '0;
        unique case (paddr)
            CTRL_ADDR:  rd_mux = 32'(fall_through_mode_ff);
            STAT_ADDR:  rd_mux = 32'({init_done, cbyte_ff, bbyte_ff, be_ff,
                                      c_irc_ff, a_ora_ff, b_rdy_ff, a_ira_ff});
            LEVEL_ADDR: rd_mux = 32'({lvl2, lvl1});
            default:    apb_hit = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end
        else
        begin
            pready_ff  <= apb_setup;
            pslverr_ff <= apb_setup && !apb_hit;
            prdata_ff  <= (apb_setup && !pwrite) ? rd_mux : '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            fall_through_mode_ff <= FALL_THROUGH_MODE_RST;
        else if (psel && penable && pready_ff && pwrite && paddr == CTRL_ADDR)
            fall_through_mode_ff <= pwdata[CTRL_FALL_THROUGH_MODE];
    end

    assign prdata              = prdata_ff;
    assign pready              = pready_ff;
    assign pslverr             = pslverr_ff;
    assign a_data_out          = a_out_ff;
    assign b_data_out          = b_out_ff;
    assign port_a_input_ready  = a_ira_ff;
    assign port_a_output_ready = a_ora_ff;
    assign port_b_output_ready = b_rdy_ff;
    assign port_c_input_ready  = c_irc_ff;

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    a_pack_big_word: assert property (
        c_edge && init_done && c_wr && c_idx_ff == IDX0 && be_ff && !cbyte_ff
        |=> c_pk_ff[WORD_W-1 -: HALF_W] == $past(c_din_s))
        else $error("first big-endian word not in upper half");

    a_pack_little_byte: assert property (
        c_edge && init_done && c_wr && c_idx_ff == IDX0 && !be_ff && cbyte_ff
        |=> c_pk_ff[LANE_W-1:0] == $past(c_din_s[LANE_W-1:0]))
        else $error("first little-endian byte not in low lane");

    a_unpack_big_word: assert property (
        b_edge && init_done && b_take && b_idx_ff == IDX0 && be_ff && !bbyte_ff
        |=> b_data_out == $past(b_src_hi))
        else $error("big-endian word read did not give upper half first");

    a_unpack_byte_pad: assert property (
        b_edge && init_done && b_take && bbyte_ff
        |=> b_data_out[HALF_W-1:LANE_W] == LANE_ZERO)
        else $error("byte read upper lane not cleared");

    a_endian_held: assert property (
        init_done |=> $stable(be_ff))
        else $error("byte order changed after capture");

    a_b_last_drop: assert property (
        b_edge && init_done && b_rd && b_last && !b_more && !fall_through_mode_ff
        |=> !port_b_output_ready)
        else $error("port B flag held after final part read");

    a_free_last_only: assert property (
        b_edge && init_done && !(b_take && b_last) |=> $stable(b_rp_ff))
        else $error("FIFO1 space freed before final part");

    a_a_full_drop: assert property (
        a_edge && init_done && a_full_nxt |=> !port_a_input_ready)
        else $error("port A full flag not asserted on filling write");

    a_b_flag_own_edge: assert property (
        !b_edge |=> $stable(port_b_output_ready))
        else $error("port B flag moved without port B edge");

    a_c_commit_only: assert property (
        c_edge && init_done && c_wr && !c_last |=> $stable(c_wp_ff))
        else $error("FIFO2 written before long word complete");

endmodule // bmf_core
`default_nettype wire

//--- design/bmf_pkg.sv
`default_nettype none
package bmf_pkg;
    // Long word, half word and byte lane widths
    localparam int         WORD_W     = 36;
    localparam int         HALF_W     = 18;
    localparam int         LANE_W     = 9;
    localparam int         BASE_W     = 6;
    // Each FIFO holds DEPTH long words; pointers carry one wrap bit
    localparam int         DEPTH      = 8;
    localparam int         ADDR_W     = 3;
    localparam int         PTR_W      = 4;
    localparam logic [3:0] DEPTH_P    = 4'h8;
    localparam logic [3:0] PTR_ONE    = 4'h1;
    // Part index within a long word
    localparam logic [1:0] IDX0       = 2'h0;
    localparam logic [1:0] IDX1       = 2'h1;
    localparam logic [1:0] LAST_HALF  = 2'h1;
    localparam logic [1:0] LAST_BYTE  = 2'h3;
    localparam logic [8:0] LANE_ZERO  = 9'h000;
    // Pin synchroniser width and config capture delay
    localparam int         SYNC_W     = 64;
    localparam int         INIT_ST    = 3;
    // APB register map
    localparam int         APB_AW     = 8;
    localparam logic [7:0] CTRL_ADDR  = 8'h00;
    localparam logic [7:0] STAT_ADDR  = 8'h04;
    localparam logic [7:0] LEVEL_ADDR = 8'h08;
    localparam int         CTRL_FALL_THROUGH_MODE  = 0;
    localparam logic       FALL_THROUGH_MODE_RST   = 1'b0;
endpackage
`default_nettype wire

//--- test/bmf_port_agent.sv
`timescale 1ns/10ps
`default_nettype none
module bmf_port_agent
    import bmf_pkg::*;
(
    input  wire logic              ref_clk,      // System clock
    output logic                   port_a_clock, // Port A clock pin
    output logic                   port_b_clock, // Port B clock pin
    output logic                   port_c_clock, // Port C clock pin
    output logic                   a_write_en,   // Port A write
    output logic                   a_read_en,    // Port A read
    output logic                   b_read_en,    // Port B read
    output logic                   c_write_en,   // Port C write
    output logic      [WORD_W-1:0] a_data_in,    // Port A data
    output logic      [HALF_W-1:0] c_data_in     // Port C data
);
    initial
    begin
        port_a_clock = 1'b0;
        port_b_clock = 1'b0;
        port_c_clock = 1'b0;
        a_write_en   = 1'b0;
        a_read_en    = 1'b0;
        b_read_en    = 1'b0;
        c_write_en   = 1'b0;
        a_data_in    = 36'h0;
        c_data_in    = 18'h0;
    end

    // One port clock pulse; clocks stand still between pulses
    task automatic pulse(input int p);
        repeat (3) @(posedge ref_clk);
        case (p)
            0: port_a_clock <= 1'b1;
            1: port_b_clock <= 1'b1;
            default: port_c_clock <= 1'b1;
        endcase
        repeat (4) @(posedge ref_clk);
        port_a_clock <= 1'b0;
        port_b_clock <= 1'b0;
        port_c_clock <= 1'b0;
        a_write_en   <= 1'b0;
        a_read_en    <= 1'b0;
        b_read_en    <= 1'b0;
        c_write_en   <= 1'b0;
        // Released data must not keep showing the old value
        a_data_in    <= ~a_data_in;
        c_data_in    <= ~c_data_in;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic a_edge(input logic we, input logic re, input logic [WORD_W-1:0] d);
        @(posedge ref_clk);
        a_write_en <= we;
        a_read_en  <= re;
        if (we) a_data_in <= d;
        pulse(0);
    endtask

    task automatic b_edge(input logic re);
        @(posedge ref_clk);
        b_read_en <= re;
        pulse(1);
    endtask

    task automatic c_edge(input logic we, input logic [HALF_W-1:0] d);
        @(posedge ref_clk);
        c_write_en <= we;
        if (we) c_data_in <= d;
        pulse(2);
    endtask
endmodule // bmf_port_agent
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
    import bmf_pkg::*;
;
    logic              ref_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd_q;
    logic              port_a_clock, port_b_clock, port_c_clock;
    logic              a_write_en, a_read_en, b_read_en, c_write_en;
    logic              byte_order_select, port_b_width_select, port_c_width_select;
    logic [WORD_W-1:0] a_data_in, a_data_out;
    logic [HALF_W-1:0] c_data_in, b_data_out;
    logic              port_a_input_ready, port_a_output_ready;
    logic              port_b_output_ready, port_c_input_ready;
    logic              err_q, big, bm;
    int                fails, checked;

    bmf_core dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .port_a_clock, .port_b_clock, .port_c_clock, .a_write_en, .a_read_en,
        .b_read_en, .c_write_en, .byte_order_select, .port_b_width_select,
        .port_c_width_select, .a_data_in, .c_data_in, .a_data_out, .b_data_out,
        .port_a_input_ready, .port_a_output_ready, .port_b_output_ready, .port_c_input_ready);
    bmf_port_agent ag (.ref_clk, .port_a_clock, .port_b_clock, .port_c_clock, .a_write_en,
        .a_read_en, .b_read_en, .c_write_en, .a_data_in, .c_data_in);

    always #5 ref_clk = ~ref_clk;

    // Part k of a long word in transfer order for the current setup
    function automatic logic [HALF_W-1:0] part(input logic [WORD_W-1:0] w, input int k);
        int l;
        l = big ? 3 - k : k;
        if (bm) return {LANE_ZERO, w[l*LANE_W +: LANE_W]};
        l = big ? 1 - k : k;
        return w[l*HALF_W +: HALF_W];
    endfunction

    task automatic chk(input string what, input logic [WORD_W-1:0] exp,
                       input logic [WORD_W-1:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            fails++;
        end
    endtask

    task automatic chkf(input string what, input logic exp, input logic got);
        chk(what, {35'h0, exp}, {35'h0, got});
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd_q     = prdata;
        err_q    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic be, input logic b8, input logic c8);
        big = be;
        bm  = b8;
        @(posedge ref_clk);
        rst                 <= 1'b1;
        byte_order_select   <= be;
        port_b_width_select <= b8;
        port_c_width_select <= c8;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        ag.a_edge(1'b0, 1'b0, 36'h0);
        ag.b_edge(1'b0);
        ag.c_edge(1'b0, 18'h0);
    endtask

    task automatic t_regs();
        do_reset(1'b1, 1'b1, 1'b0);
        @(posedge ref_clk);
        byte_order_select <= 1'b0;
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk("ctrl reset", {35'h0, FALL_THROUGH_MODE_RST}, {4'h0, rd_q});
        apb(1'b0, STAT_ADDR, 32'h0);
        chk("status", 36'h0B9, {4'h0, rd_q});
        apb(1'b1, 8'h0C, 32'hFFFFFFFF);
        chkf("write error", 1'b1, err_q);
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped read", 36'h0, {4'h0, rd_q});
        chkf("read error", 1'b1, err_q);
        apb(1'b1, CTRL_ADDR, 32'hFFFFFFFF);
        apb(1'b0, CTRL_ADDR, 32'h0);
        chk("ctrl bits", 36'h1, {4'h0, rd_q});
        $display("test regs done");
    endtask

    task automatic t_match(input logic be, input logic b8);
        logic [WORD_W-1:0] w;
        int                n;
        w = 36'h9A5C3E671;
        n = b8 ? 4 : 2;
        do_reset(be, b8, b8);
        ag.a_edge(1'b1, 1'b0, w);
        ag.b_edge(1'b0);
        chkf("b ready early", 1'b0, port_b_output_ready);
        ag.b_edge(1'b0);
        chkf("b ready", 1'b1, port_b_output_ready);
        for (int k = 0; k < n; k++)
        begin
            ag.b_edge(1'b1);
            chk("b part", {18'h0, part(w, k)}, {18'h0, b_data_out});
        end
        chkf("b empty", 1'b0, port_b_output_ready);
        w = ~w;
        for (int k = 0; k < n; k++)
        begin
            if (k == n - 1)
            begin
                repeat (2) ag.a_edge(1'b0, 1'b0, 36'h0);
                chkf("a partial", 1'b0, port_a_output_ready);
            end
            ag.c_edge(1'b1, part(w, k));
        end
        ag.a_edge(1'b0, 1'b0, 36'h0);
        chkf("a ready early", 1'b0, port_a_output_ready);
        ag.a_edge(1'b0, 1'b0, 36'h0);
        chkf("a ready", 1'b1, port_a_output_ready);
        ag.a_edge(1'b0, 1'b1, 36'h0);
        chk("a word", w, a_data_out);
        chkf("a empty", 1'b0, port_a_output_ready);
        $display("test match done");
    endtask

    task automatic t_fall_through_mode();
        logic [WORD_W-1:0] w;
        w = 36'h3C96A5E18;
        do_reset(1'b0, 1'b0, 1'b0);
        apb(1'b1, CTRL_ADDR, 32'h1);
        ag.a_edge(1'b1, 1'b0, w);
        repeat (2) ag.b_edge(1'b0);
        chkf("fall_through_mode b early", 1'b0, port_b_output_ready);
        ag.b_edge(1'b0);
        chkf("fall_through_mode b ready", 1'b1, port_b_output_ready);
        chk("fall_through_mode b first", {18'h0, part(w, 0)}, {18'h0, b_data_out});
        ag.b_edge(1'b1);
        chk("fall_through_mode b second", {18'h0, part(w, 1)}, {18'h0, b_data_out});
        chkf("fall_through_mode b held", 1'b1, port_b_output_ready);
        ag.b_edge(1'b1);
        chkf("fall_through_mode b done", 1'b0, port_b_output_ready);
        ag.c_edge(1'b1, part(w, 0));
        ag.c_edge(1'b1, part(w, 1));
        repeat (2) ag.a_edge(1'b0, 1'b0, 36'h0);
        chkf("fall_through_mode a early", 1'b0, port_a_output_ready);
        ag.a_edge(1'b0, 1'b0, 36'h0);
        chkf("fall_through_mode a ready", 1'b1, port_a_output_ready);
        chk("fall_through_mode a word", w, a_data_out);
        ag.a_edge(1'b0, 1'b1, 36'h0);
        chkf("fall_through_mode a done", 1'b0, port_a_output_ready);
        $display("test fall-through done");
    endtask

    task automatic t_full1(input logic fw);
        logic [WORD_W-1:0] w;
        w = 36'h123456789;
        do_reset(1'b1, 1'b0, 1'b0);
        if (fw) apb(1'b1, CTRL_ADDR, 32'h1);
        for (int k = 0; k < DEPTH; k++)
            ag.a_edge(1'b1, 1'b0, w + 36'(k));
        chkf("a full", 1'b0, port_a_input_ready);
        ag.a_edge(1'b1, 1'b0, 36'hFFFFFFFFF);
        apb(1'b0, LEVEL_ADDR, 32'h0);
        chk("level", 36'h8, {4'h0, rd_q});
        repeat (2) ag.b_edge(1'b0);
        ag.b_edge(1'b1);
        chk("b upper", {18'h0, part(w, 0)}, {18'h0, b_data_out});
        repeat (2) ag.a_edge(1'b0, 1'b0, 36'h0);
        chkf("a full mid", 1'b0, port_a_input_ready);
        ag.b_edge(1'b1);
        chk("b lower", {18'h0, part(w, 1)}, {18'h0, b_data_out});
        ag.a_edge(1'b0, 1'b0, 36'h0);
        chkf("a full late", 1'b0, port_a_input_ready);
        ag.a_edge(1'b0, 1'b0, 36'h0);
        chkf("a space", 1'b1, port_a_input_ready);
        $display("test fifo1 full done");
    endtask

    task automatic t_full2();
        do_reset(1'b0, 1'b1, 1'b1);
        for (int k = 0; k < 4 * DEPTH; k++)
        begin
            if (k == 4 * DEPTH - 1) chkf("c room", 1'b1, port_c_input_ready);
            ag.c_edge(1'b1, {9'h000, 9'(k)});
        end
        chkf("c full", 1'b0, port_c_input_ready);
        repeat (2) ag.a_edge(1'b0, 1'b0, 36'h0);
        ag.a_edge(1'b0, 1'b1, 36'h0);
        chk("a bytes", {9'h003, 9'h002, 9'h001, 9'h000}, a_data_out);
        ag.c_edge(1'b0, 18'h0);
        chkf("c room early", 1'b0, port_c_input_ready);
        ag.c_edge(1'b0, 18'h0);
        chkf("c room back", 1'b1, port_c_input_ready);
        $display("test fifo2 full done");
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial
    begin
        ref_clk             = 1'b0;
        rst                 = 1'b1;
        psel                = 1'b0;
        penable             = 1'b0;
        pwrite              = 1'b0;
        paddr               = 8'h00;
        pwdata              = 32'h0;
        byte_order_select   = 1'b0;
        port_b_width_select = 1'b0;
        port_c_width_select = 1'b0;
        big                 = 1'b0;
        bm                  = 1'b0;
        fails               = 0;
        checked             = 0;
        t_regs();
        for (int c = 0; c < 4; c++)
            t_match(c[1], c[0]);
        t_fall_through_mode();
        t_full1(1'b0);
        t_full1(1'b1);
        t_full2();
        report_and_stop();
    end

    initial
    begin
        #100000;
        fails++;
        $display("watchdog expired");
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
